//--- cclm_pkg.sv
// constants for the converter clock and load-measure supervisor
// assumes a single 100 MHz clock and a word-aligned Avalon-MM register map
package cclm_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS     = 10;
  localparam int MEAS_TIME_NS      = 50000;                       // longest measurement, 50 us
  localparam int MEAS_CYCLES_DFLT  = MEAS_TIME_NS / CLK_PERIOD_NS; // rounded down
  localparam int SPREAD_TICK_NS    = 1000;                        // dither step interval
  localparam int SPREAD_TICK_CYC   = SPREAD_TICK_NS / CLK_PERIOD_NS;
  localparam int CLK_MHZ           = 1000 / CLK_PERIOD_NS;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [5:0] OFS_MEAS_SEL   = 6'h00;
  localparam logic [5:0] OFS_RESULT_LO  = 6'h04;
  localparam logic [5:0] OFS_RESULT_HI  = 6'h08;
  localparam logic [5:0] OFS_INT_FLAG   = 6'h0C;
  localparam logic [5:0] OFS_INT_MASK   = 6'h10;
  localparam logic [5:0] OFS_PLL_CTRL   = 6'h14;
  localparam logic [5:0] OFS_CONFIG     = 6'h18;
  localparam logic [5:0] OFS_BUCK_CTRL  = 6'h1C;
  localparam logic [5:0] OFS_BOOST_CFG  = 6'h20;
  localparam logic [5:0] OFS_STATUS     = 6'h24;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_MEAS_DONE   = 0;  // flag and mask
  localparam int BIT_SYNC_CLK    = 1;  // flag and mask
  localparam int BIT_PLL_EN      = 0;
  localparam int POS_EXT_FREQ    = 8;  // five bits
  localparam int BIT_SPREAD_EN   = 0;
  localparam int POS_BUCK_FPWM   = 0;  // two bits
  localparam int POS_BUCK_EN     = 2;  // two bits
  localparam int BIT_BOOST_EN    = 4;
  localparam int POS_BOOST_VOLTAGE_SETTING  = 0;  // two bits
  localparam int POS_BOOST_CURRENT_LIMIT  = 2;  // two bits
  localparam int BIT_BOOST_RDIS  = 4;

  // ****************************************
  // reset values and limits
  // ****************************************
  localparam logic [1:0] MASK_RST       = 2'h0;
  localparam logic [1:0] BOOST_VOLTAGE_SETTING_RST = 2'h0;  // 4.9 V, 0.1 V per code
  localparam logic [1:0] BOOST_CURRENT_LIMIT_RST = 2'h0;
  localparam logic       BOOST_RDIS_RST = 1'b1;
  localparam logic [4:0] EXT_FREQ_RST   = 5'h01;
  localparam logic [4:0] EXT_FREQ_MAX   = 5'h18;  // 24 MHz
  localparam int         DET_LO_PCT     = 70;     // -30 %
  localparam int         DET_HI_PCT     = 110;    // +10 %
  localparam logic [3:0] SPREAD_TOP     = 4'hF;   // step 15 is 0.85 x fsw

endpackage

//--- cclm_top.sv
// converter clock selection, sync clock detector, spread dither and buck load measurement
// assumes all inputs synchronous to clk; registers on an Avalon-MM slave with waitrequest
//
// Contract
// - select field picks which buck is measured
// - any select write starts new measurement
// - measured buck forced to PWM meanwhile
// - measurement finishes within 50 us
// - done sets flag, mask gates the interrupt
// - 9-bit result, 8 low, 1 high register
// - result step is 20 mA, 10.22 A full
// - bucks go PFM at light load unforced
// - forced PWM keeps buck out of PFM
// - spread band from 0.85 fsw to fsw
// - spread only with PLL off, all converters
// - five-bit nominal external clock, 1..24 MHz
// - detector accepts -30 to +10 percent only
// - PLL off: detector off, no flag, RC
// - PLL on: fall back to RC without clock
// - PLL on: flag on clock loss and return
// - PLL on: flag if clock missing at startup
// - sync mask gates sync flag from interrupt
// - boost voltage 4.9..5.2 V, four codes
// - boost always forced PWM
// - boost mode fixed from OTP only
// - boost discharge enable resets to one
// - enable from standby moves to active
//
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
module cclm_top #(
  parameter int MEAS_CYCLES = cclm_pkg::MEAS_CYCLES_DFLT
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        ext_sync_clock_input,
  input  wire logic        otp_load_done,
  input  wire logic        otp_boost_bypass,
  input  wire logic [8:0]  load_sense_code,
  input  wire logic [1:0]  buck_heavy_load,
  output logic      [1:0]  buck_enable,
  output logic             boost_enable,
  output logic      [1:0]  buck_pfm,
  output logic             boost_forced_pwm,
  output logic             boost_bypass_mode,
  output logic      [1:0]  boost_voltage_setting,
  output logic      [1:0]  boost_current_limit,
  output logic             boost_discharge_enable,
  output logic             pll_enable,
  output logic             use_ext_clock,
  output logic      [3:0]  spread_step,
  output logic             measure_busy,
  output logic             measure_buck_sel,
  output logic             irq_out
);
  import cclm_pkg::*;

  localparam logic [13:0] MEAS_LAST = 14'(MEAS_CYCLES - 1);
  localparam logic [6:0]  TICK_LAST = 7'(SPREAD_TICK_CYC - 1);

  logic        ack_q;
  logic        wr_en;
  logic        meas_start;
  logic        meas_done;
  logic [13:0] meas_cnt_q;
  logic [8:0]  result_q;
  logic [1:0]  flag_q;
  logic [1:0]  flag_d;
  logic [1:0]  mask_q;
  logic [4:0]  ext_freq_q;
  logic        spread_en_q;
  logic [1:0]  fpwm_q;
  logic        active_q;
  logic        ext_prev_q;
  logic [7:0]  period_q;
  logic        ext_valid_q;
  logic        ext_valid_prev_q;
  logic        ext_edge;
  logic [19:0] lo_prod;
  logic [19:0] hi_prod;
  logic        period_ok;
  logic        period_late;
  logic        any_en_d;
  logic        sync_set;
  logic [6:0]  tick_cnt_q;
  logic        tick;
  logic        spread_dn_q;
  logic [31:0] rd_mux;

  // ****************************************
  // bus slave
  // ****************************************

  // every access waits one cycle; write lands and read data stand on the second
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign wr_en           = avs_write & ack_q;
  assign meas_start      = wr_en & (avs_address == OFS_MEAS_SEL);

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  // read multiplexer, unmapped offsets read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      OFS_MEAS_SEL:  rd_mux[0] = measure_buck_sel;
      OFS_RESULT_LO: rd_mux[7:0] = result_q[7:0];
      OFS_RESULT_HI: rd_mux[0] = result_q[8];
      OFS_INT_FLAG:  rd_mux[1:0] = flag_q;
      OFS_INT_MASK:  rd_mux[1:0] = mask_q;
      OFS_PLL_CTRL: begin
        rd_mux[BIT_PLL_EN] = pll_enable;
        rd_mux[POS_EXT_FREQ +: 5] = ext_freq_q;
      end
      OFS_CONFIG:    rd_mux[BIT_SPREAD_EN] = spread_en_q;
      OFS_BUCK_CTRL: begin
        rd_mux[POS_BUCK_FPWM +: 2] = fpwm_q;
        rd_mux[POS_BUCK_EN +: 2] = buck_enable;
        rd_mux[BIT_BOOST_EN] = boost_enable;
      end
      OFS_BOOST_CFG: begin
        rd_mux[POS_BOOST_VOLTAGE_SETTING +: 2] = boost_voltage_setting;
        rd_mux[POS_BOOST_CURRENT_LIMIT +: 2] = boost_current_limit;
        rd_mux[BIT_BOOST_RDIS] = boost_discharge_enable;
      end
      OFS_STATUS:    rd_mux[5:0] = {boost_bypass_mode, active_q, use_ext_clock, ext_valid_q, buck_pfm[1] & 1'b0,
                                    measure_busy};
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // read data registered in the waiting cycle, stands when waitrequest drops
  always_ff @(posedge clk) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack_q) begin
      avs_readdata <= rd_mux;
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************

  // control bits written by software
  always_ff @(posedge clk) begin
    if (srst) begin
      mask_q                 <= MASK_RST;
      pll_enable             <= 1'b0;
      ext_freq_q             <= EXT_FREQ_RST;
      spread_en_q            <= 1'b0;
      fpwm_q                 <= 2'h0;
      buck_enable            <= 2'h0;
      boost_enable           <= 1'b0;
      boost_voltage_setting  <= BOOST_VOLTAGE_SETTING_RST;
      boost_current_limit    <= BOOST_CURRENT_LIMIT_RST;
      boost_discharge_enable <= BOOST_RDIS_RST;
      measure_buck_sel       <= 1'b0;
    end else if (wr_en) begin
      case (avs_address)
        OFS_MEAS_SEL:  measure_buck_sel <= avs_writedata[0];
        OFS_INT_MASK:  mask_q <= avs_writedata[1:0];
        OFS_PLL_CTRL: begin
          pll_enable <= avs_writedata[BIT_PLL_EN];
          ext_freq_q <= avs_writedata[POS_EXT_FREQ +: 5];
        end
        OFS_CONFIG:    spread_en_q <= avs_writedata[BIT_SPREAD_EN];
        OFS_BUCK_CTRL: begin
          fpwm_q       <= avs_writedata[POS_BUCK_FPWM +: 2];
          buck_enable  <= avs_writedata[POS_BUCK_EN +: 2];
          boost_enable <= avs_writedata[BIT_BOOST_EN];
        end
        OFS_BOOST_CFG: begin
          boost_voltage_setting  <= avs_writedata[POS_BOOST_VOLTAGE_SETTING +: 2];
          boost_current_limit    <= avs_writedata[POS_BOOST_CURRENT_LIMIT +: 2];
          boost_discharge_enable <= avs_writedata[BIT_BOOST_RDIS];
        end
        default: ;
      endcase
    end
  end

  // boost mode taken from OTP only at load, never from the bus
  always_ff @(posedge clk) begin
    if (srst) begin
      boost_bypass_mode <= 1'b0;
    end else if (otp_load_done) begin
      boost_bypass_mode <= otp_boost_bypass;
    end
  end

  // boost has no PFM path
  assign boost_forced_pwm = 1'b1;

  // ****************************************
  // load current measurement
  // ****************************************

  // a restart landing on the last count discards the old run
  assign meas_done = measure_busy & (meas_cnt_q == MEAS_LAST) & ~meas_start;

  // sequence timer; a new select write restarts it
  always_ff @(posedge clk) begin
    if (srst) begin
      measure_busy <= 1'b0;
      meas_cnt_q   <= 14'h0000;
    end else if (meas_start) begin
      measure_busy <= 1'b1;
      meas_cnt_q   <= 14'h0000;
    end else if (meas_done) begin
      measure_busy <= 1'b0;
    end else if (measure_busy) begin
      meas_cnt_q <= meas_cnt_q + 14'h0001;
    end
  end

  // result in 20 mA steps, held until the next completion
  always_ff @(posedge clk) begin
    if (srst) begin
      result_q <= 9'h000;
    end else if (meas_done) begin
      result_q <= load_sense_code;
    end
  end

  // auto PFM only when light, unforced and not under measurement
  always_ff @(posedge clk) begin
    if (srst) begin
      buck_pfm <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        buck_pfm[i] <= buck_enable[i] & ~buck_heavy_load[i] & ~fpwm_q[i]
                       & ~((measure_busy & (measure_buck_sel == 1'(i)))
                           | (meas_start & (avs_writedata[0] == 1'(i))));
      end
    end
  end

  // ****************************************
  // sync clock detector
  // ****************************************

  // period in clk cycles P is valid when 0.7 N <= 100/P <= 1.1 N
  assign ext_edge    = ext_sync_clock_input & ~ext_prev_q;
  assign lo_prod     = 20'(DET_LO_PCT) * 20'(ext_freq_q) * 20'(period_q);
  assign hi_prod     = 20'(DET_HI_PCT) * 20'(ext_freq_q) * 20'(period_q);
  assign period_ok   = (hi_prod >= 20'(CLK_MHZ * 100)) & (lo_prod <= 20'(CLK_MHZ * 100))
                       & (ext_freq_q != 5'h00) & (ext_freq_q <= EXT_FREQ_MAX);
  assign period_late = (lo_prod > 20'(CLK_MHZ * 100)) | (period_q == 8'hFF);

  // period counter and validity; held off while the PLL is disabled
  always_ff @(posedge clk) begin
    if (srst | ~pll_enable) begin
      ext_prev_q  <= 1'b0;
      period_q    <= 8'h00;
      ext_valid_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_sync_clock_input;
      if (ext_edge) begin
        period_q    <= 8'h01;
        ext_valid_q <= period_ok;
      end else begin
        if (period_q != 8'hFF) begin
          period_q <= period_q + 8'h01;
        end
        if (period_late) begin
          ext_valid_q <= 1'b0;
        end
      end
    end
  end

  // clock source select falls back to RC without a valid clock
  always_ff @(posedge clk) begin
    if (srst) begin
      use_ext_clock <= 1'b0;
    end else begin
      use_ext_clock <= pll_enable & ext_valid_q;
    end
  end

  // ****************************************
  // device state and interrupt flags
  // ****************************************

  assign any_en_d = |buck_enable | boost_enable;

  // standby to active once any converter is enabled
  always_ff @(posedge clk) begin
    if (srst) begin
      active_q         <= 1'b0;
      ext_valid_prev_q <= 1'b0;
    end else begin
      active_q         <= any_en_d;
      ext_valid_prev_q <= ext_valid_q;
    end
  end

  assign sync_set = pll_enable & ((ext_valid_q ^ ext_valid_prev_q)
                    | (~ext_valid_q & (otp_load_done | (any_en_d & ~active_q))));

  // sticky flags, write one to clear, a set in the same cycle wins
  always_comb begin
    flag_d = flag_q;
    if (wr_en & (avs_address == OFS_INT_FLAG)) begin
      flag_d = flag_q & ~avs_writedata[1:0];
    end
    flag_d[BIT_MEAS_DONE] = flag_d[BIT_MEAS_DONE] | meas_done;
    flag_d[BIT_SYNC_CLK]  = flag_d[BIT_SYNC_CLK] | sync_set;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      flag_q <= 2'h0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // masks gate each flag from the interrupt line
  assign irq_out = |(flag_q & ~mask_q);

  // ****************************************
  // spread spectrum dither
  // ****************************************

  assign tick = (tick_cnt_q == TICK_LAST);

  // triangle step 0..15 maps fsw down to 0.85 fsw; RC clock only
  always_ff @(posedge clk) begin
    if (srst | ~spread_en_q | pll_enable) begin
      tick_cnt_q  <= 7'h00;
      spread_step <= 4'h0;
      spread_dn_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick ? 7'h00 : tick_cnt_q + 7'h01;
      if (tick) begin
        if (spread_dn_q) begin
          spread_step <= spread_step - 4'h1;
          spread_dn_q <= (spread_step != 4'h1);
        end else begin
          spread_step <= spread_step + 4'h1;
          spread_dn_q <= (spread_step == SPREAD_TOP - 4'h1);
        end
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************

  sequence seq_meas_start;
    meas_start;
  endsequence

  sequence seq_meas_run;
    measure_busy && meas_cnt_q == 14'h0000;
  endsequence

  a_meas_restart: assert property (@(posedge clk) disable iff (srst) seq_meas_start |=> seq_meas_run)
    else $error("measurement did not start on select write");
  a_meas_bound: assert property (@(posedge clk) disable iff (srst) measure_busy |-> meas_cnt_q <= MEAS_LAST)
    else $error("measurement ran past its limit");
  a_meas_flag: assert property (@(posedge clk) disable iff (srst) meas_done |=> flag_q[BIT_MEAS_DONE] && !measure_busy)
    else $error("done flag missing after measurement");
  a_irq_gate: assert property (@(posedge clk) disable iff (srst) mask_q == 2'h3 |-> !irq_out)
    else $error("interrupt raised by a masked flag");
  a_pwm_hold: assert property (@(posedge clk) disable iff (srst)
    measure_busy ##1 measure_busy |-> !buck_pfm[measure_buck_sel])
    else $error("measured buck left PWM");
  a_fpwm_hold: assert property (@(posedge clk) disable iff (srst) fpwm_q[0] ##1 fpwm_q[0] |-> !buck_pfm[0])
    else $error("forced buck entered PFM");
  a_rc_fallback: assert property (@(posedge clk) disable iff (srst) !pll_enable |=> !use_ext_clock)
    else $error("external clock used with PLL off");
  a_result_hold: assert property (@(posedge clk) disable iff (srst) !meas_done |=> $stable(result_q))
    else $error("result changed without completion");
  a_sync_edge: assert property (@(posedge clk) disable iff (srst)
    pll_enable && $changed(ext_valid_prev_q) && $past(pll_enable) |-> ##[0:1] flag_q[BIT_SYNC_CLK])
    else $error("sync flag missing on clock change");
  a_spread_off: assert property (@(posedge clk) disable iff (srst) pll_enable |=> spread_step == 4'h0)
    else $error("spread active with PLL on");
  a_bypass_fixed: assert property (@(posedge clk) disable iff (srst) !otp_load_done |=> $stable(boost_bypass_mode))
    else $error("boost mode changed outside OTP load");
  a_rdis_reset: assert property (@(posedge clk) $fell(srst) |-> boost_discharge_enable)
    else $error("discharge enable not set after reset");

endmodule

//--- cclm_sync_src.sv
// model of the external sync clock source feeding the supervisor
// assumes the bench clock; output is a level that changes only after clk edges
`timescale 1ns/100ps
module cclm_sync_src (
  input  wire logic       clk,
  input  wire logic       run,
  input  wire logic [7:0] period,
  output logic            sync_out
);
  // ********************
  // period generator
  // ********************
  logic [7:0] cnt_q;

  // counts clk cycles of one period; held at zero while stopped
  always_ff @(posedge clk) begin
    if (!run || cnt_q >= period - 8'h01) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // high for the first half; stands still low between bursts
  always_ff @(posedge clk) begin
    sync_out <= run && (cnt_q < (period >> 1));
  end
endmodule

//--- testbench.sv
// self-checking bench for the clock supervisor and load measurement block
// assumes cclm_pkg, cclm_top and cclm_sync_src are compiled first
`timescale 1ns/100ps
module testbench;
  import cclm_pkg::*;
  localparam int MC = 20;  // short measurement run
  // ********************
  // signals
  // ********************
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        ext_sync_clock_input;
  logic        otp_load_done = 1'b0;
  logic        otp_boost_bypass = 1'b0;
  logic [8:0]  load_sense_code = 9'h000;
  logic [1:0]  buck_heavy_load = 2'h0;
  logic [1:0]  buck_enable, buck_pfm, boost_voltage_setting, boost_current_limit;
  logic        boost_enable, boost_forced_pwm, boost_bypass_mode, boost_discharge_enable;
  logic        pll_enable, use_ext_clock, measure_busy, measure_buck_sel, irq_out;
  logic [3:0]  spread_step;
  logic        src_run = 1'b0;
  logic [7:0]  src_per = 8'h14;
  logic [31:0] rd;
  logic        top_seen;
  int          fail_count = 0;
  int          check_count = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  cclm_top #(.MEAS_CYCLES(MC)) cclm_top_i (
    .clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .ext_sync_clock_input, .otp_load_done, .otp_boost_bypass,
    .load_sense_code, .buck_heavy_load, .buck_enable, .boost_enable, .buck_pfm,
    .boost_forced_pwm, .boost_bypass_mode, .boost_voltage_setting, .boost_current_limit,
    .boost_discharge_enable, .pll_enable, .use_ext_clock, .spread_step, .measure_busy,
    .measure_buck_sel, .irq_out
  );
  cclm_sync_src cclm_sync_src_i (.clk, .run(src_run), .period(src_per), .sync_out(ext_sync_clock_input));

  // ********************
  // tasks
  // ********************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // one Avalon access, held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      fail_count++;
      end_sim();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask

  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // reads until the masked value matches, bounded
  task automatic poll(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    int n;
    n = 0;
    do begin
      acc(1'b0, a, 32'h0);
      n++;
    end while ((rd & m) !== e && n < 300);
    chk(rd & m, e);
    if ((rd & m) !== e) end_sim();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ********************
  // hang guard
  // ********************
  initial begin
    cyc(90000);
    fail_count++;
    end_sim();
  end

  // ********************
  // main sequence
  // ********************
  initial begin
    cyc(20);
    srst <= 1'b0;
    cyc(1);
    rdc(OFS_BOOST_CFG, 32'h10);
    chk(32'(boost_forced_pwm), 32'h1);
    rdc(OFS_PLL_CTRL, 32'h100);
    rdc(6'h3C, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_BOOST_CFG, 32'(i) | 32'((3 - i) << 2));
      cyc(1);
      chk(32'(boost_voltage_setting), 32'(i));
      chk(32'(boost_current_limit), 32'(3 - i));
      chk(32'(boost_discharge_enable), 32'h0);
    end
    $display("test boost done");
    wr(OFS_BUCK_CTRL, 32'h0C);
    cyc(3);
    chk(32'(buck_pfm), 32'h3);
    chk(32'(buck_enable), 32'h3);
    poll(OFS_STATUS, 32'h10, 32'h10);
    rdc(OFS_INT_FLAG, 32'h0);
    buck_heavy_load <= 2'h1;
    cyc(3);
    chk(32'(buck_pfm), 32'h2);
    buck_heavy_load <= 2'h0;
    wr(OFS_BUCK_CTRL, 32'h0D);
    cyc(3);
    chk(32'(buck_pfm), 32'h2);
    $display("test modes done");
    load_sense_code <= 9'h1FF;
    wr(OFS_MEAS_SEL, 32'h1);
    cyc(3);
    chk(32'(measure_busy), 32'h1);
    chk(32'(measure_buck_sel), 32'h1);
    chk(32'(buck_pfm), 32'h0);
    cyc(MC);
    chk(32'(measure_busy), 32'h0);
    cyc(1);
    chk(32'(buck_pfm), 32'h2);
    rdc(OFS_RESULT_LO, 32'hFF);
    rdc(OFS_RESULT_HI, 32'h1);
    chk(32'(irq_out), 32'h1);
    load_sense_code <= 9'h0A5;
    rdc(OFS_RESULT_LO, 32'hFF);
    rdc(OFS_INT_FLAG, 32'h1);
    wr(OFS_INT_MASK, 32'h1);
    cyc(1);
    chk(32'(irq_out), 32'h0);
    wr(OFS_INT_FLAG, 32'h1);
    wr(OFS_MEAS_SEL, 32'h0);
    cyc(MC / 2);
    wr(OFS_MEAS_SEL, 32'h0);
    cyc(MC / 2 + 4);
    chk(32'(measure_busy), 32'h1);
    cyc(MC);
    rdc(OFS_RESULT_LO, 32'hA5);
    rdc(OFS_RESULT_HI, 32'h0);
    rdc(OFS_INT_FLAG, 32'h1);
    wr(OFS_INT_FLAG, 32'h1);
    chk(32'(measure_buck_sel), 32'h0);
    $display("test measure done");
    src_run <= 1'b1;
    wr(OFS_CONFIG, 32'h1);
    top_seen = 1'b0;
    repeat (2000) begin
      @(posedge clk);
      if (spread_step === SPREAD_TOP) top_seen = 1'b1;
    end
    chk(32'(top_seen), 32'h1);
    chk(32'(use_ext_clock), 32'h0);
    rdc(OFS_INT_FLAG, 32'h0);
    wr(OFS_PLL_CTRL, 32'h501);
    poll(OFS_STATUS, 32'hC, 32'hC);
    chk(32'(pll_enable), 32'h1);
    chk(32'(spread_step), 32'h0);
    rdc(OFS_INT_FLAG, 32'h2);
    chk(32'(irq_out), 32'h1);
    wr(OFS_INT_MASK, 32'h3);
    cyc(1);
    chk(32'(irq_out), 32'h0);
    wr(OFS_INT_FLAG, 32'h2);
    src_run <= 1'b0;
    poll(OFS_STATUS, 32'hC, 32'h0);
    rdc(OFS_INT_FLAG, 32'h2);
    wr(OFS_INT_FLAG, 32'h2);
    for (int i = 0; i < 2; i++) begin
      src_per <= (i == 0) ? 8'h12 : 8'h1D;
      src_run <= 1'b1;
      cyc(400);
      poll(OFS_STATUS, 32'h4, 32'h0);
      rdc(OFS_INT_FLAG, 32'h0);
      src_run <= 1'b0;
      cyc(1);
    end
    $display("test sync done");
    wr(OFS_BUCK_CTRL, 32'h0);
    wr(OFS_INT_FLAG, 32'h3);
    otp_boost_bypass <= 1'b1;
    otp_load_done <= 1'b1;
    cyc(1);
    otp_load_done <= 1'b0;
    otp_boost_bypass <= 1'b0;
    cyc(3);
    rdc(OFS_INT_FLAG, 32'h2);
    chk(32'(boost_bypass_mode), 32'h1);
    wr(OFS_INT_FLAG, 32'h2);
    wr(OFS_BUCK_CTRL, 32'h10);
    cyc(2);
    chk(32'(boost_enable), 32'h1);
    rdc(OFS_INT_FLAG, 32'h2);
    chk(32'(boost_bypass_mode), 32'h1);
    $display("test startup done");
    end_sim();
  end
endmodule
